// *** rdpo_pkg.sv ***
// Purpose: shared constants for the dual receive parallel output port
// Assumes: 125 MHz system clock, 32-bit plain register port
// Notes:   offsets are byte addresses of aligned words
package rdpo_pkg;
    localparam int          NUM_CH         = 2;
    localparam int          CHAR_W         = 10;
    localparam int          CNT_W          = 8;
    localparam int          ST_W           = 3;
    localparam int          SYNC_W         = 5;

    localparam logic [7:0]  ADDR_STATUS    = 8'h00;
    localparam logic [7:0]  ADDR_MASK      = 8'h04;
    localparam logic [7:0]  ADDR_CTRL      = 8'h08;
    localparam logic [7:0]  ADDR_STATE     = 8'h0C;

    // status / mask layout
    localparam int          EV_FAULT_POS   = 0;
    localparam int          EV_PWRDN_POS   = 2;
    localparam int          EV_W           = 4;

    // control layout, per channel ch at CTRL_CH_STRIDE*ch
    localparam int          CTRL_CH_STRIDE = 8;
    localparam int          CTRL_RATE_POS  = 0;
    localparam int          CTRL_ST_POS    = 1;
    localparam int          CTRL_OE1_POS   = 3;
    localparam int          CTRL_OE2_POS   = 4;
    localparam logic [15:0] CTRL_RESET     = 16'h1818;

    // state layout, per channel ch at STATE_CH_STRIDE*ch
    localparam int          STATE_CH_STRIDE = 4;
    localparam int          STATE_FAULT_POS = 0;
    localparam int          STATE_PWRDN_POS = 1;
    localparam int          STATE_CLK_POS   = 2;
    localparam int          STATE_STP_POS   = 3;

    localparam logic [1:0]  SELFTEST_ON    = 2'b10;
    localparam logic        RATE_FULL      = 1'b0;

    // entry n holds {status pin, data[1:0]} for self-test state n
    localparam logic [23:0] SELFTEST_MAP_DEF = 24'hFAC688;
endpackage

// *** rdpo_sync.sv ***
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: inputs are levels from outside the clk domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module rdpo_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    always_comb
    begin
        meta_next = din;
        out_next  = meta_reg;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            out_reg  <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            out_reg  <= out_next;
        end
    end

    assign dout = out_reg;
endmodule
`default_nettype wire

// *** rdpo_port.sv ***
// Purpose: two-channel receive parallel output port with register access
// Assumes: recovered characters arrive as strobes on clk; pins are async
// Notes:   interface clocks are rebuilt from character strobes on clk
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - full rate: data changes with true interface clock rising edge
// - half rate: data changes on both edges of the interface clock pair
// - interface clock pair runs while strobes arrive and stops on a stall, rate chosen per channel
// - self-test control 10 puts status on status pin and data[1:0]
// - power-down flag high when both retimer output enables are 0
// - retimer clock equals interface clock rate, or twice it at half rate
// - retimer clock comes from the same character strobes, toggling with each interface clock edge
// - training clock serves only as fallback frequency reference
// - low reset pin returns all state to initial values
// - use-local-ref low locks to training clock, link fault held low
module rdpo_port #(
    parameter logic [23:0] SELFTEST_MAP = rdpo_pkg::SELFTEST_MAP_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        resetPinN,
    input  wire logic [1:0]  cdr_training_clk,
    input  wire logic [1:0]  use_local_ref,
    input  wire logic [1:0]  cdrLocked,
    input  wire logic [1:0]  carrierOk,
    input  wire logic [1:0]  recStrobe,
    input  wire logic [9:0]  recChar0,
    input  wire logic [9:0]  recChar1,
    input  wire logic [2:0]  selftestState0,
    input  wire logic [2:0]  selftestState1,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output var  logic [31:0] regRdata,
    output var  logic        irq,
    output var  logic [9:0]  rx_char_out0,
    output var  logic [9:0]  rx_char_out1,
    output var  logic [1:0]  rx_iface_clk_p,
    output var  logic [1:0]  rx_iface_clk_n,
    output var  logic [1:0]  selftest_status_pin,
    output var  logic [1:0]  retimer_pwrdn_flag,
    output var  logic [1:0]  retimer_clk_out,
    output var  logic [1:0]  link_fault_ind
);
    localparam int NC = rdpo_pkg::NUM_CH;
    localparam int CW = rdpo_pkg::CHAR_W;
    localparam int KW = rdpo_pkg::CNT_W;

    function automatic logic [2:0] stLookup(input logic [2:0] st);
        stLookup = SELFTEST_MAP[st*3 +: 3];
    endfunction

    function automatic logic [15:0] ctrlField(input logic [15:0] c, input int ch, input int pos);
        ctrlField = 16'(c >> (ch * rdpo_pkg::CTRL_CH_STRIDE + pos));
    endfunction

    logic [rdpo_pkg::SYNC_W-1:0] syncOut;
    logic [1:0]                  trgS;
    logic [1:0]                  ulcS;
    logic                        resetPinS;
    logic                        lrst;

    rdpo_sync #(
        .W (rdpo_pkg::SYNC_W)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({resetPinN, use_local_ref, cdr_training_clk}),
        .dout (syncOut)
    );

    assign trgS      = syncOut[1:0];
    assign ulcS      = syncOut[3:2];
    assign resetPinS = syncOut[4];

    // pin reset is only seen after three flops (two synchroniser stages plus rstPinSeen_reg), so it cannot glitch the core
    logic rstPinSeen_reg;
    logic rstPinSeen_next;
    assign lrst = rst | ~rstPinSeen_reg;

    always_comb
    begin
        rstPinSeen_next = resetPinS;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rstPinSeen_reg <= 1'b0;
        else
            rstPinSeen_reg <= rstPinSeen_next;
    end

    // register file
    logic [15:0]                 ctrl_reg;
    logic [15:0]                 ctrl_next;
    logic [rdpo_pkg::EV_W-1:0]   status_reg;
    logic [rdpo_pkg::EV_W-1:0]   status_next;
    logic [rdpo_pkg::EV_W-1:0]   mask_reg;
    logic [rdpo_pkg::EV_W-1:0]   mask_next;
    logic [31:0]                 rdata_reg;
    logic [31:0]                 rdata_next;
    logic                        irq_reg;
    logic                        irq_next;
    logic [rdpo_pkg::EV_W-1:0]   events;
    logic [15:0]                 stateWord;

    // channel state
    logic [NC-1:0][CW-1:0]       char_reg;
    logic [NC-1:0][CW-1:0]       char_next;
    logic [NC-1:0]               iclk_reg;
    logic [NC-1:0]               iclk_next;
    logic [NC-1:0]               rclk_reg;
    logic [NC-1:0]               rclk_next;
    logic [NC-1:0][KW-1:0]       cnt_reg;
    logic [NC-1:0][KW-1:0]       cnt_next;
    logic [NC-1:0][KW-1:0]       period_reg;
    logic [NC-1:0][KW-1:0]       period_next;
    logic [NC-1:0]               stp_reg;
    logic [NC-1:0]               stp_next;
    logic [NC-1:0]               pwrdn_reg;
    logic [NC-1:0]               pwrdn_next;
    logic [NC-1:0]               fault_reg;
    logic [NC-1:0]               fault_next;
    logic [NC-1:0]               trgPrev_reg;
    logic [NC-1:0]               trgPrev_next;

    logic [NC-1:0][CW-1:0]       recChar;
    logic [NC-1:0][2:0]          stState;

    assign recChar = {recChar1, recChar0};
    assign stState = {selftestState1, selftestState0};

    always_comb
    begin
        logic        strobe;
        logic        mid;
        logic        halfRate;
        logic [CW-1:0] src;
        logic [2:0]  code;
        strobe = 1'b0;
        mid = 1'b0;
        halfRate = 1'b0;
        src = '0;
        code = '0;
        char_next    = char_reg;
        iclk_next    = iclk_reg;
        rclk_next    = rclk_reg;
        cnt_next     = cnt_reg;
        period_next  = period_reg;
        stp_next     = stp_reg;
        pwrdn_next   = pwrdn_reg;
        fault_next   = fault_reg;
        trgPrev_next = trgS;
        for (int ch = 0; ch < NC; ch++)
        begin
            halfRate = ctrlField(ctrl_reg, ch, rdpo_pkg::CTRL_RATE_POS) != 16'h0000
                       && ctrlField(ctrl_reg, ch, rdpo_pkg::CTRL_RATE_POS) % 2 == 1;
            // training edges only stand in while no data is being recovered
            if (!ulcS[ch] || !cdrLocked[ch])
            begin
                strobe = trgS[ch] & ~trgPrev_reg[ch];
                src = '0;
            end
            else
            begin
                strobe = recStrobe[ch];
                src = recChar[ch];
            end
            // midpoint needs a measured period; the counter saturates on a stall
            mid = (cnt_reg[ch] == (period_reg[ch] >> 1)) && !strobe
                  && period_reg[ch] > 8'h01;
            if (strobe)
            begin
                period_next[ch] = cnt_reg[ch] + 8'h01;
                cnt_next[ch] = '0;
            end
            else if (cnt_reg[ch] != 8'hFF)
            begin
                cnt_next[ch] = cnt_reg[ch] + 8'h01;
            end
            if (strobe)
            begin
                char_next[ch] = src;
                code = stLookup(stState[ch]);
                if (2'(ctrlField(ctrl_reg, ch, rdpo_pkg::CTRL_ST_POS))
                    == rdpo_pkg::SELFTEST_ON)
                begin
                    // upper bits pass unchanged; receiver must not trust them
                    char_next[ch][1:0] = code[1:0];
                    stp_next[ch] = code[2];
                end
                else
                begin
                    stp_next[ch] = 1'b0;
                end
            end
            if (!halfRate)
            begin
                if (strobe)
                    iclk_next[ch] = 1'b1;
                else if (mid)
                    iclk_next[ch] = 1'b0;
            end
            else if (strobe)
            begin
                iclk_next[ch] = ~iclk_reg[ch];
            end
            // retimer toggles where the interface clock does, plus midpoints at half rate
            if (strobe || (mid && !halfRate))
                rclk_next[ch] = ~rclk_reg[ch];
            else if (mid && halfRate)
                rclk_next[ch] = ~rclk_reg[ch];
            pwrdn_next[ch] = 1'(ctrlField(ctrl_reg, ch, rdpo_pkg::CTRL_OE1_POS)) == 1'b0
                          && 1'(ctrlField(ctrl_reg, ch, rdpo_pkg::CTRL_OE2_POS)) == 1'b0;
            fault_next[ch] = ulcS[ch] & carrierOk[ch] & cdrLocked[ch];
        end
    end

    always_ff @(posedge clk)
    begin
        if (lrst)
        begin
            char_reg    <= '0;
            iclk_reg    <= '0;
            rclk_reg    <= '0;
            cnt_reg     <= '0;
            period_reg  <= '0;
            stp_reg     <= '0;
            pwrdn_reg   <= '0;
            fault_reg   <= '0;
            trgPrev_reg <= '0;
        end
        else
        begin
            char_reg    <= char_next;
            iclk_reg    <= iclk_next;
            rclk_reg    <= rclk_next;
            cnt_reg     <= cnt_next;
            period_reg  <= period_next;
            stp_reg     <= stp_next;
            pwrdn_reg   <= pwrdn_next;
            fault_reg   <= fault_next;
            trgPrev_reg <= trgPrev_next;
        end
    end

    // events: link fault newly asserted (indicator fell), power-down flag changed
    always_comb
    begin
        events = '0;
        for (int ch = 0; ch < NC; ch++)
        begin
            events[rdpo_pkg::EV_FAULT_POS + ch] = fault_reg[ch] & ~fault_next[ch];
            events[rdpo_pkg::EV_PWRDN_POS + ch] = pwrdn_reg[ch] ^ pwrdn_next[ch];
        end
    end

    always_comb
    begin
        stateWord = '0;
        for (int ch = 0; ch < NC; ch++)
        begin
            stateWord[ch*rdpo_pkg::STATE_CH_STRIDE + rdpo_pkg::STATE_FAULT_POS] = fault_reg[ch];
            stateWord[ch*rdpo_pkg::STATE_CH_STRIDE + rdpo_pkg::STATE_PWRDN_POS] = pwrdn_reg[ch];
            stateWord[ch*rdpo_pkg::STATE_CH_STRIDE + rdpo_pkg::STATE_CLK_POS]   = iclk_reg[ch];
            stateWord[ch*rdpo_pkg::STATE_CH_STRIDE + rdpo_pkg::STATE_STP_POS]   = stp_reg[ch];
        end
    end

    always_comb
    begin
        ctrl_next   = ctrl_reg;
        mask_next   = mask_reg;
        status_next = status_reg;
        rdata_next  = '0;
        if (regWr && regAddr == rdpo_pkg::ADDR_CTRL)
            ctrl_next = regWdata[15:0];
        if (regWr && regAddr == rdpo_pkg::ADDR_MASK)
            mask_next = regWdata[rdpo_pkg::EV_W-1:0];
        if (regRd)
        begin
            case (regAddr)
                rdpo_pkg::ADDR_STATUS:
                begin
                    rdata_next = {28'h0000000, status_reg};
                    status_next = '0;
                end
                rdpo_pkg::ADDR_MASK:  rdata_next = {28'h0000000, mask_reg};
                rdpo_pkg::ADDR_CTRL:  rdata_next = {16'h0000, ctrl_reg};
                rdpo_pkg::ADDR_STATE: rdata_next = {16'h0000, stateWord};
                default:              rdata_next = '0;
            endcase
        end
        // a new event beats the read-clear in the same cycle
        status_next = status_next | events;
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge clk)
    begin
        if (lrst)
        begin
            ctrl_reg   <= rdpo_pkg::CTRL_RESET;
            mask_reg   <= '0;
            status_reg <= '0;
            rdata_reg  <= '0;
            irq_reg    <= 1'b0;
        end
        else
        begin
            ctrl_reg   <= ctrl_next;
            mask_reg   <= mask_next;
            status_reg <= status_next;
            rdata_reg  <= rdata_next;
            irq_reg    <= irq_next;
        end
    end

    assign regRdata            = rdata_reg;
    assign irq                 = irq_reg;
    assign rx_char_out0        = char_reg[0];
    assign rx_char_out1        = char_reg[1];
    assign rx_iface_clk_p      = iclk_reg;
    assign rx_iface_clk_n      = ~iclk_reg;
    assign selftest_status_pin = stp_reg;
    assign retimer_pwrdn_flag  = pwrdn_reg;
    assign retimer_clk_out     = rclk_reg;
    assign link_fault_ind      = fault_reg;
endmodule
`default_nettype wire

// *** rdpo_port_checker.sv ***
// Purpose: pin-level checks for the receive parallel output port
// Assumes: ctrl changes only through the register port
// Notes:   ctrl is mirrored from writes; a guard covers the reset pin path
`timescale 1ns/100ps
`default_nettype none
module rdpo_port_checker #(
    parameter logic [23:0] SELFTEST_MAP = rdpo_pkg::SELFTEST_MAP_DEF
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        resetPinN,
    input wire logic [1:0]  use_local_ref,
    input wire logic [1:0]  cdrLocked,
    input wire logic [1:0]  carrierOk,
    input wire logic [1:0]  recStrobe,
    input wire logic [9:0]  recChar1,
    input wire logic [2:0]  selftestState0,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic [9:0]  rx_char_out0,
    input wire logic [9:0]  rx_char_out1,
    input wire logic [1:0]  rx_iface_clk_p,
    input wire logic [1:0]  rx_iface_clk_n,
    input wire logic [1:0]  selftest_status_pin,
    input wire logic [1:0]  retimer_pwrdn_flag,
    input wire logic [1:0]  retimer_clk_out,
    input wire logic [1:0]  link_fault_ind
);
    logic [15:0] ctrlSh;
    logic [3:0]  pinSh;
    logic        guard;
    // the pin reset lands a few edges late inside, so stay quiet a little longer
    assign guard = rst | ~resetPinN | ~(&pinSh);
    always_ff @(posedge clk)
    begin
        pinSh <= rst ? 4'h0 : {pinSh[2:0], resetPinN};
        if (guard)
            ctrlSh <= rdpo_pkg::CTRL_RESET;
        else if (regWr && regAddr == rdpo_pkg::ADDR_CTRL)
            ctrlSh <= regWdata[15:0];
    end
    function automatic logic [2:0] code(input logic [2:0] s);
        return SELFTEST_MAP[3*s +: 3];
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (guard);
    sequence refHeld0;
        use_local_ref[0] [*4];
    endsequence
    sequence refHeld1;
        use_local_ref[1] [*4];
    endsequence
    full_rate_edge_a: assert property (
        (ctrlSh[0] == rdpo_pkg::RATE_FULL && !$stable(rx_char_out0)) |-> $rose(rx_iface_clk_p[0]))
        else $error("ch0 data moved without a rising interface clock");
    half_rate_edge_a: assert property (
        (ctrlSh[8] && !$stable(rx_char_out1)) |-> !$stable(rx_iface_clk_p[1]))
        else $error("ch1 data moved without an interface clock edge");
    clk_pair_a: assert property (
        rx_iface_clk_n == ~rx_iface_clk_p)
        else $error("interface clock pair not complementary");
    char_latency_a: assert property (
        (refHeld1 ##0 (recStrobe[1] && cdrLocked[1] && ctrlSh[10:9] != rdpo_pkg::SELFTEST_ON))
        |=> rx_char_out1 == $past(recChar1))
        else $error("ch1 character not presented one cycle after strobe");
    selftest_code_a: assert property (
        (refHeld0 ##0 (recStrobe[0] && cdrLocked[0] && ctrlSh[2:1] == rdpo_pkg::SELFTEST_ON))
        |=> {selftest_status_pin[0], rx_char_out0[1:0]} == code($past(selftestState0)))
        else $error("ch0 self-test code wrong");
    pwrdn_flag_a: assert property (
        retimer_pwrdn_flag[0] == $past(!ctrlSh[3] && !ctrlSh[4]))
        else $error("ch0 power-down flag does not follow output enables");
    fault_hold_a: assert property (
        !use_local_ref[1] [*4] |-> !link_fault_ind[1])
        else $error("ch1 link fault not held low on local reference");
    fault_follow_a: assert property (
        refHeld0 |-> link_fault_ind[0] == $past(carrierOk[0] && cdrLocked[0]))
        else $error("ch0 link fault indicator wrong");
    retimer_edge0_a: assert property (
        !$stable(rx_iface_clk_p[0]) |-> !$stable(retimer_clk_out[0]))
        else $error("ch0 retimer clock missed an interface clock edge");
    retimer_edge1_a: assert property (
        !$stable(rx_iface_clk_p[1]) |-> !$stable(retimer_clk_out[1]))
        else $error("ch1 retimer clock missed an interface clock edge");
    read_idle_a: assert property (
        !$past(regRd) |-> regRdata == 32'h0)
        else $error("read data not zero outside read answer");
endmodule
bind rdpo_port rdpo_port_checker #(.SELFTEST_MAP(SELFTEST_MAP)) u_chk (
    .clk(clk), .rst(rst), .resetPinN(resetPinN), .use_local_ref(use_local_ref),
    .cdrLocked(cdrLocked), .carrierOk(carrierOk), .recStrobe(recStrobe),
    .recChar1(recChar1), .selftestState0(selftestState0), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .rx_char_out0(rx_char_out0), .rx_char_out1(rx_char_out1),
    .rx_iface_clk_p(rx_iface_clk_p), .rx_iface_clk_n(rx_iface_clk_n),
    .selftest_status_pin(selftest_status_pin), .retimer_pwrdn_flag(retimer_pwrdn_flag),
    .retimer_clk_out(retimer_clk_out),
    .link_fault_ind(link_fault_ind));
`default_nettype wire

// *** rdpo_coproc_model.sv ***
// Purpose: downstream receiver taking characters off one channel
// Assumes: interface clock is sampled by the system clock
// Notes:   counts the interface clock edges it accepted
`timescale 1ns/100ps
`default_nettype none
module rdpo_coproc_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ifaceClk,
    input  wire logic [9:0] charIn,
    input  wire logic       statusPin,
    input  wire logic       halfRate,
    input  wire logic       selftestOn,
    output var  logic [9:0] got,
    output var  logic       gotPin,
    output var  logic [7:0] edges
);
    logic prevClk;
    always_ff @(posedge clk)
    begin
        prevClk <= ifaceClk;
        if (rst)
        begin
            got    <= 10'h000;
            gotPin <= 1'b0;
            edges  <= 8'h00;
        end
        else if ((ifaceClk && !prevClk) || (halfRate && ifaceClk != prevClk))
        begin
            got    <= selftestOn ? {8'h00, charIn[1:0]} : charIn;
            gotPin <= selftestOn ? statusPin : 1'b0;
            edges  <= edges + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** rdpo_port_tb_top.sv ***
// Purpose: self-checking bench for the receive parallel output port
// Assumes: ch0 stays full rate, ch1 runs half rate after setup
// Notes:   outputs are read just after an edge, before that edge's updates
`timescale 1ns/100ps
`default_nettype none
module rdpo_port_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        resetPinN = 1'b1;
    logic [1:0]  trg = 2'b00;
    logic [1:0]  ulr = 2'b11;
    logic [1:0]  locked = 2'b11;
    logic [1:0]  carrier = 2'b11;
    logic [1:0]  recStrobe = 2'b00;
    logic [9:0]  recChar [2] = '{10'h000, 10'h000};
    logic [2:0]  stState [2] = '{3'h0, 3'h0};
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        st0On = 1'b0;
    logic [31:0] regRdata;
    logic        irq;
    logic [9:0]  charOut [2];
    logic [1:0]  clkP;
    logic [1:0]  stPin;
    logic [1:0]  pwrdn;
    logic [1:0]  fault;
    logic [9:0]  got [2];
    logic [1:0]  gotPin;
    logic [7:0]  edges [2];
    int          mismatches = 0;
    int          checks_done = 0;
    initial forever #4 clk = ~clk;
    // link clock kept off the system clock's phase
    initial
    begin
        #3;
        forever #62.5 trg = ~trg;
    end
    rdpo_port i_dut (
        .clk(clk), .rst(rst), .resetPinN(resetPinN), .cdr_training_clk(trg),
        .use_local_ref(ulr), .cdrLocked(locked), .carrierOk(carrier), .recStrobe(recStrobe),
        .recChar0(recChar[0]), .recChar1(recChar[1]), .selftestState0(stState[0]),
        .selftestState1(stState[1]), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .irq(irq), .rx_char_out0(charOut[0]),
        .rx_char_out1(charOut[1]), .rx_iface_clk_p(clkP), .rx_iface_clk_n(),
        .selftest_status_pin(stPin), .retimer_pwrdn_flag(pwrdn), .retimer_clk_out(),
        .link_fault_ind(fault));
    for (genvar c = 0; c < 2; c++)
    begin : g_rx
        rdpo_coproc_model u_rx (
            .clk(clk), .rst(rst), .ifaceClk(clkP[c]), .charIn(charOut[c]),
            .statusPin(stPin[c]), .halfRate(c == 1), .selftestOn(c == 0 && st0On),
            .got(got[c]), .gotPin(gotPin[c]), .edges(edges[c]));
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        @(posedge clk);
        d = regRdata;
    endtask
    task automatic strb(input int ch, input logic [9:0] c, input logic [2:0] s);
        recStrobe[ch] <= 1'b1;
        recChar[ch]   <= c;
        stState[ch]   <= s;
        @(posedge clk);
        recStrobe[ch] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // two strobes at loop spacing: the second one measures the period, so the
    // full-rate clock falls before the next strobe; the second leaves data unchanged
    task automatic prime(input int ch, input logic [9:0] c, input logic [2:0] s);
        strb(ch, c, s);
        strb(ch, c, s);
    endtask
    task automatic t_regs;
        logic [31:0] d;
        rd(rdpo_pkg::ADDR_CTRL, d);
        chk("ctrlReset", {16'h0, rdpo_pkg::CTRL_RESET}, d);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, d);
        chk("unmapped", 32'h0, d);
    endtask
    task automatic t_rate(input int ch);
        logic [7:0] e;
        prime(ch, charOut[ch], 3'h0);
        e = edges[ch];
        for (int i = 0; i < 4; i++)
        begin
            strb(ch, 10'(10'h2A5 + 10'(i * 77)), 3'h0);
            chk("char", {22'h0, 10'(10'h2A5 + 10'(i * 77))}, {22'h0, got[ch]});
        end
        chk("clkEdges", 32'd4, {24'h0, 8'(edges[ch] - e)});
    endtask
    task automatic t_selftest;
        wr(rdpo_pkg::ADDR_CTRL, 32'h191C);
        st0On <= 1'b1;
        prime(0, 10'h3FF, 3'h0);
        for (int n = 0; n < 8; n++)
        begin
            strb(0, 10'h3FF, 3'(n));
            chk("stCode", {29'h0, rdpo_pkg::SELFTEST_MAP_DEF[3*n +: 3]},
                {29'h0, gotPin[0], got[0][1:0]});
        end
        st0On <= 1'b0;
    endtask
    task automatic t_pwrdn;
        logic [31:0] d;
        rd(rdpo_pkg::ADDR_STATUS, d);
        wr(rdpo_pkg::ADDR_MASK, 32'h4);
        wr(rdpo_pkg::ADDR_CTRL, 32'h1900);
        @(posedge clk);
        chk("pwrdnFlag", 32'h1, {31'h0, pwrdn[0]});
        chk("irqSet", 32'h1, {31'h0, irq});
        rd(rdpo_pkg::ADDR_STATUS, d);
        chk("statusPwrdn", 32'h4, d);
        @(posedge clk);
        chk("irqClear", 32'h0, {31'h0, irq});
        wr(rdpo_pkg::ADDR_CTRL, 32'h1918);
        @(posedge clk);
        chk("pwrdnOff", 32'h0, {31'h0, pwrdn[0]});
        rd(rdpo_pkg::ADDR_STATUS, d);
    endtask
    task automatic t_fault;
        logic [31:0] d;
        logic [7:0]  e;
        carrier[0] <= 1'b0;
        repeat (3) @(posedge clk);
        chk("faultCarrier", 32'h0, {31'h0, fault[0]});
        carrier[0] <= 1'b1;
        rd(rdpo_pkg::ADDR_STATUS, d);
        chk("statusFault", 32'h1, d);
        e = edges[1];
        ulr[1] <= 1'b0;
        repeat (40) @(posedge clk);
        chk("faultLocal", 32'h0, {31'h0, fault[1]});
        chk("trainEdges", 32'h1, {31'h0, 8'(edges[1] - e) >= 8'd2});
        chk("trainChar", 32'h0, {22'h0, got[1]});
        ulr[1] <= 1'b1;
        repeat (6) @(posedge clk);
        rd(rdpo_pkg::ADDR_STATUS, d);
    endtask
    task automatic t_pinrst;
        logic [31:0] d;
        wr(rdpo_pkg::ADDR_CTRL, 32'h0000);
        resetPinN <= 1'b0;
        repeat (5) @(posedge clk);
        resetPinN <= 1'b1;
        repeat (6) @(posedge clk);
        rd(rdpo_pkg::ADDR_CTRL, d);
        chk("ctrlPinReset", {16'h0, rdpo_pkg::CTRL_RESET}, d);
        chk("pwrdnPinReset", 32'h0, {30'h0, pwrdn});
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_regs();
        t_rate(0);
        wr(rdpo_pkg::ADDR_CTRL, 32'h1918);
        t_rate(1);
        t_selftest();
        t_pwrdn();
        t_fault();
        t_pinrst();
        tally_and_finish();
    end
endmodule
`default_nettype wire
